// [verilog/phy_basic_control_register.sv]
// Basic control register of the PHY with its serial management slave and mode resolution.
`include "phy_ctrl_consts.svh"
`default_nettype none
module phy_basic_control_register #(
  parameter int LB_DELAY = `LOOPBACK_DELAY_CYCLES
) (
  // Core clock and synchronous reset.
  input  wire logic       core_clk,
  input  wire logic       reset,
  // Serial management pins; the data pin is split into in, out and enable.
  input  wire logic       mdc,
  input  wire logic       mdio_in,
  output var  logic       mdio_out,
  output var  logic       mdio_oe_n,
  // Configuration pins and PHY address strap.
  input  wire logic       select_pin_a,
  input  wire logic       rate_select_pin,
  input  wire logic       autoneg_select_pin,
  input  wire logic       duplex_select_pin,
  input  wire logic [4:0] phy_addr_strap,
  // Auto-negotiation engine, on the core clock.
  input  wire logic       negotiated_speed_100,
  input  wire logic       negotiated_full_duplex,
  input  wire logic       autoneg_begun,
  output var  logic       an_restart,
  // Events for the rest of the management register set.
  output var  logic       soft_reset_active,
  output var  logic       latch_reinit,
  output var  logic       mgmt_read_strobe,
  output var  logic [4:0] mgmt_read_reg,
  // Resolved operating mode.
  output var  logic       speed_100,
  output var  logic       full_duplex,
  output var  logic       an_enable,
  output var  logic       rate_status_100,
  // MAC interface on the link clock.
  input  wire logic       mii_clk,
  input  wire logic       tx_en,
  input  wire logic [3:0] txd,
  input  wire logic [3:0] pma_rxd,
  input  wire logic       pma_rx_dv,
  input  wire logic       pma_crs,
  input  wire logic       pma_col,
  output var  logic [3:0] rxd,
  output var  logic       rx_dv,
  output var  logic       crs,
  output var  logic       col,
  output var  logic       mac_out_en_n,
  // Twisted-pair side.
  output var  logic [3:0] tp_txd,
  output var  logic       tp_tx_en,
  output var  logic       tp_transmit_tristate,
  output var  logic       tp_rx_enable
);

  import phy_ctrl_pkg::*;

  core_state_t cur;
  core_state_t next_cur;
  logic [10:0] pins_s;
  logic        mdc_s;
  logic        mdio_s;
  logic        sel_s;
  logic        rate_s;
  logic        an_pin_s;
  logic        dpx_s;
  logic [4:0]  strap_s;
  logic [11:0] header;
  logic [15:0] wdata;
  logic [15:0] wd;
  logic        do_write;
  logic        an_after;

  // Default register value; the isolate bit follows the strapped address.
  function automatic logic [15:0] default_ctrl(input logic [4:0] addr);
    logic [15:0] v;
    v = `CTRL_RESET_VALUE;
    if (addr == 5'h00) begin
      v = v | `CTRL_ISOLATE_VALUE;
    end
    return v;
  endfunction : default_ctrl

  // Word answered to a read; reserved bits are forced to zero.
  function automatic logic [15:0] read_word(input logic [4:0] addr, input logic [15:0] ctrl);
    logic [15:0] v;
    v = 16'h0000;
    if (addr == `CTRL_REG_ADDR) begin
      v = ctrl & `CTRL_WRITABLE_MASK;
    end
    return v;
  endfunction : read_word

  // Every management and configuration pin is asynchronous to the core clock and passes two flip-flops first.
  sync2 #(.WIDTH(11)) u_pin_sync (
    .clk      (core_clk),
    .async_in ({mdc, mdio_in, select_pin_a, rate_select_pin, autoneg_select_pin,
                duplex_select_pin, phy_addr_strap}),
    .sync_out (pins_s)
  );

  assign mdc_s    = pins_s[10];
  assign mdio_s   = pins_s[9];
  assign sel_s    = pins_s[8];
  assign rate_s   = pins_s[7];
  assign an_pin_s = pins_s[6];
  assign dpx_s    = pins_s[5];
  assign strap_s  = pins_s[4:0];

  // Frame receiver, register update, soft reset sequencer and mode resolution.
  always_comb begin
    next_cur                  = cur;
    header                    = {cur.shift[10:0], mdio_s};
    wdata                     = {cur.shift[14:0], mdio_s};
    wd                        = 16'h0000;
    do_write                  = 1'b0;
    an_after                  = 1'b0;
    next_cur.mdc_last         = mdc_s;
    next_cur.an_restart       = 1'b0;
    next_cur.latch_reinit     = 1'b0;
    next_cur.mgmt_read_strobe = 1'b0;

    // Each rising edge of the management clock moves the frame on by one bit.
    if (mdc_s & ~cur.mdc_last) begin
      case (cur.state)
        MG_HUNT: begin
          // Ones are counted up to the preamble length; a zero too early starts over.
          if (mdio_s) begin
            if (cur.bit_cnt != `MDIO_PREAMBLE_BITS) begin
              next_cur.bit_cnt = cur.bit_cnt + 6'h01;
            end
          end else if (cur.bit_cnt == `MDIO_PREAMBLE_BITS) begin
            next_cur.state   = MG_START;
            next_cur.bit_cnt = 6'h00;
          end else begin
            next_cur.bit_cnt = 6'h00;
          end
        end
        MG_START: begin
          next_cur.state   = mdio_s ? MG_HEADER : MG_HUNT;
          next_cur.bit_cnt = 6'h00;
        end
        MG_HEADER: begin
          next_cur.shift   = {cur.shift[14:0], mdio_s};
          next_cur.bit_cnt = cur.bit_cnt + 6'h01;
          if (cur.bit_cnt == `MDIO_HEADER_LAST) begin
            next_cur.state    = MG_TURN;
            next_cur.bit_cnt  = 6'h00;
            next_cur.is_read  = (header[11:10] == `MDIO_OP_READ);
            next_cur.reg_addr = header[4:0];
            next_cur.addr_hit = (header[9:5] == cur.phy_addr) &&
                                ((header[11:10] == `MDIO_OP_READ) ||
                                 (header[11:10] == `MDIO_OP_WRITE));
            if ((header[11:10] == `MDIO_OP_READ) && (header[9:5] == cur.phy_addr)) begin
              // Reads stay open during soft reset so software can poll bit 15.
              next_cur.shift            = read_word(header[4:0], cur.ctrl);
              next_cur.mgmt_read_strobe = 1'b1;
              next_cur.mgmt_read_reg    = header[4:0];
            end
          end
        end
        MG_TURN: begin
          // The second turnaround bit is driven low so the master sees the pin taken.
          if (cur.bit_cnt == 6'h00) begin
            next_cur.bit_cnt = 6'h01;
            if (cur.is_read & cur.addr_hit) begin
              next_cur.mdio_oe_n = 1'b0;
              next_cur.mdio_out  = 1'b0;
            end
          end else begin
            next_cur.state   = MG_DATA;
            next_cur.bit_cnt = 6'h00;
            if (cur.is_read & cur.addr_hit) begin
              next_cur.mdio_out = cur.shift[15];
              next_cur.shift    = {cur.shift[14:0], 1'b0};
            end
          end
        end
        MG_DATA: begin
          next_cur.bit_cnt = cur.bit_cnt + 6'h01;
          if (cur.is_read) begin
            if (cur.addr_hit && (cur.bit_cnt != `MDIO_DATA_LAST)) begin
              next_cur.mdio_out = cur.shift[15];
              next_cur.shift    = {cur.shift[14:0], 1'b0};
            end
          end else begin
            next_cur.shift = {cur.shift[14:0], mdio_s};
          end
          // The rise that samples the last data bit closes the frame and frees the pin.
          if (cur.bit_cnt == `MDIO_DATA_LAST) begin
            next_cur.state     = MG_HUNT;
            next_cur.bit_cnt   = 6'h00;
            next_cur.mdio_oe_n = 1'b1;
            next_cur.mdio_out  = 1'b0;
            do_write           = ~cur.is_read & cur.addr_hit &
                                 (cur.reg_addr == `CTRL_REG_ADDR);
          end
        end
        default: begin
          next_cur.state = MG_HUNT;
        end
      endcase
    end

    // Soft reset runs out its count with bit 15 held high and writes refused.
    if (cur.ctrl[`CTRL_BIT_RESET]) begin
      if (cur.rst_cnt <= 8'h01) begin
        next_cur.ctrl         = default_ctrl(cur.phy_addr);
        next_cur.rst_cnt      = 8'h00;
        next_cur.latch_reinit = 1'b1;
      end else begin
        next_cur.rst_cnt = cur.rst_cnt - 8'h01;
      end
    end else begin
      // The engine's acknowledge clears restart; a write of one with auto-negotiation enabled in the same cycle wins.
      if (autoneg_begun) begin
        next_cur.ctrl[`CTRL_BIT_RESTART] = 1'b0;
      end
      if (do_write) begin
        wd       = wdata & `CTRL_WRITABLE_MASK;
        an_after = sel_s ? wd[`CTRL_BIT_ANEG] : an_pin_s;
        if (wd[`CTRL_BIT_RESET]) begin
          next_cur.ctrl    = default_ctrl(cur.phy_addr) | 16'h8000;
          next_cur.rst_cnt = 8'(`SOFT_RESET_CYCLES);
        end else begin
          if (wd[`CTRL_BIT_LOWPWR] & ~cur.ctrl[`CTRL_BIT_LOWPWR]) begin
            next_cur.latch_reinit = 1'b1;
          end
          next_cur.ctrl[14:10] = wd[14:10];
          next_cur.ctrl[8:7]   = wd[8:7];
          next_cur.ctrl[6:0]   = 7'h00;
          // A zero written to the restart bit leaves a pending restart alone.
          if (wd[`CTRL_BIT_RESTART] & an_after) begin
            next_cur.ctrl[`CTRL_BIT_RESTART] = 1'b1;
            next_cur.an_restart              = 1'b1;
          end
        end
      end
    end
    next_cur.soft_reset_active = next_cur.ctrl[`CTRL_BIT_RESET];

    // Mode resolution; in hardware mode the stored bits 13, 12 and 8 are ignored.
    if (~sel_s) begin
      next_cur.an_enable   = an_pin_s;
      next_cur.speed_100   = an_pin_s ? negotiated_speed_100 : rate_s;
      next_cur.full_duplex = an_pin_s ? negotiated_full_duplex : dpx_s;
    end else begin
      next_cur.an_enable   = cur.ctrl[`CTRL_BIT_ANEG];
      next_cur.speed_100   = cur.ctrl[`CTRL_BIT_ANEG] ? negotiated_speed_100 :
                             cur.ctrl[`CTRL_BIT_SPEED];
      if (cur.ctrl[`CTRL_BIT_LOOPBACK]) begin
        next_cur.full_duplex = 1'b1;
      end else if (cur.ctrl[`CTRL_BIT_ANEG]) begin
        next_cur.full_duplex = negotiated_full_duplex;
      end else begin
        next_cur.full_duplex = cur.ctrl[`CTRL_BIT_DUPLEX];
      end
    end
    // The rate status always follows the rate the link is running at.
    next_cur.rate_status_100 = next_cur.speed_100;

    // Synchronous reset; the strap is caught from its synchroniser while reset is held.
    if (reset) begin
      next_cur                   = '0;
      next_cur.state             = MG_HUNT;
      next_cur.mdio_oe_n         = 1'b1;
      // A management clock already high at release must not look like a fresh rise.
      next_cur.mdc_last          = mdc_s;
      next_cur.phy_addr          = strap_s;
      next_cur.ctrl              = default_ctrl(strap_s);
      next_cur.soft_reset_active = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    cur <= next_cur;
  end

  // Link side sees the control bits through its own synchronisers.
  mii_link #(.LB_DELAY(LB_DELAY)) u_link (
    .mii_clk              (mii_clk),
    .link_reset_req       (cur.soft_reset_active),
    .loopback             (cur.ctrl[`CTRL_BIT_LOOPBACK]),
    .coltest              (cur.ctrl[`CTRL_BIT_COLTEST]),
    .low_power            (cur.ctrl[`CTRL_BIT_LOWPWR]),
    .isolate              (cur.ctrl[`CTRL_BIT_ISOLATE]),
    .tx_en                (tx_en),
    .txd                  (txd),
    .pma_rxd              (pma_rxd),
    .pma_rx_dv            (pma_rx_dv),
    .pma_crs              (pma_crs),
    .pma_col              (pma_col),
    .rxd                  (rxd),
    .rx_dv                (rx_dv),
    .crs                  (crs),
    .col                  (col),
    .mac_out_en_n         (mac_out_en_n),
    .tp_txd               (tp_txd),
    .tp_tx_en             (tp_tx_en),
    .tp_transmit_tristate (tp_transmit_tristate),
    .tp_rx_enable         (tp_rx_enable)
  );

  // Core outputs straight from the state register.
  assign mdio_out          = cur.mdio_out;
  assign mdio_oe_n         = cur.mdio_oe_n;
  assign an_restart        = cur.an_restart;
  assign soft_reset_active = cur.soft_reset_active;
  assign latch_reinit      = cur.latch_reinit;
  assign mgmt_read_strobe  = cur.mgmt_read_strobe;
  assign mgmt_read_reg     = cur.mgmt_read_reg;
  assign speed_100         = cur.speed_100;
  assign full_duplex       = cur.full_duplex;
  assign an_enable         = cur.an_enable;
  assign rate_status_100   = cur.rate_status_100;

endmodule : phy_basic_control_register
`default_nettype wire

// [verilog/phy_ctrl_consts.svh]
// Offsets, bit positions, reset values and timing counts of the basic control register block.
`ifndef PHY_CTRL_CONSTS_SVH
`define PHY_CTRL_CONSTS_SVH

// Management address of the basic control register.
`define CTRL_REG_ADDR        5'h00

// Bit positions inside the basic control register.
`define CTRL_BIT_RESET       15
`define CTRL_BIT_LOOPBACK    14
`define CTRL_BIT_SPEED       13
`define CTRL_BIT_ANEG        12
`define CTRL_BIT_LOWPWR      11
`define CTRL_BIT_ISOLATE     10
`define CTRL_BIT_RESTART     9
`define CTRL_BIT_DUPLEX      8
`define CTRL_BIT_COLTEST     7

// Bits 6 to 0 are reserved and always read as zero.
`define CTRL_WRITABLE_MASK   16'hff80

// Default without the isolate bit: rate 100 Mbps and auto-negotiation enabled.
`define CTRL_RESET_VALUE     16'h3000
`define CTRL_ISOLATE_VALUE   16'h0400

// Serial management frame fields.
`define MDIO_PREAMBLE_BITS   6'h20
`define MDIO_HEADER_LAST     6'h0b
`define MDIO_DATA_LAST       6'h0f
`define MDIO_OP_READ         2'h2
`define MDIO_OP_WRITE        2'h1

// Core clock rate and soft reset duration, rounded up to whole cycles.
`define CORE_CLK_MHZ         250
`define SOFT_RESET_TIME_NS   64
`define SOFT_RESET_CYCLES    ((`SOFT_RESET_TIME_NS * `CORE_CLK_MHZ + 999) / 1000)

// Loopback latency bound in link clock cycles, one nibble of four bits per cycle.
`define NIBBLE_BITS          4
`define LOOPBACK_MAX_BITS    512
`define LOOPBACK_MAX_CYCLES  (`LOOPBACK_MAX_BITS / `NIBBLE_BITS)
`define LOOPBACK_DELAY_CYCLES 2
`define COL_DROP_BITS        4

`endif

// [verilog/phy_ctrl_pkg.sv]
// Types shared by the basic control register block.
`default_nettype none
package phy_ctrl_pkg;

  // Receive side of a management frame.
  typedef enum logic [2:0] {
    MG_HUNT,
    MG_START,
    MG_HEADER,
    MG_TURN,
    MG_DATA
  } mgmt_state_t;

  // All state of the core clock side.
  typedef struct packed {
    mgmt_state_t state;
    logic [5:0]  bit_cnt;
    logic [15:0] shift;
    logic        is_read;
    logic        addr_hit;
    logic [4:0]  reg_addr;
    logic        mdc_last;
    logic        mdio_out;
    logic        mdio_oe_n;
    logic [15:0] ctrl;
    logic [4:0]  phy_addr;
    logic [7:0]  rst_cnt;
    logic        soft_reset_active;
    logic        an_restart;
    logic        latch_reinit;
    logic        mgmt_read_strobe;
    logic [4:0]  mgmt_read_reg;
    logic        speed_100;
    logic        full_duplex;
    logic        an_enable;
    logic        rate_status_100;
  } core_state_t;

endpackage : phy_ctrl_pkg
`default_nettype wire

// [verilog/sync2.sv]
// Two flip-flop synchroniser for a bundle of independent levels.
`default_nettype none
module sync2 #(
  parameter int WIDTH = 1
) (
  // Destination clock.
  input  wire logic             clk,
  // Level from another domain and its synchronised copy.
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_state_t;

  sync_state_t cur;
  sync_state_t next_cur;

  // The first stage feeds only the second; no reset so straps pass through during reset.
  always_comb begin
    next_cur        = cur;
    next_cur.stage1 = async_in;
    next_cur.stage2 = cur.stage1;
  end

  always_ff @(posedge clk) begin
    cur <= next_cur;
  end

  assign sync_out = cur.stage2;

endmodule : sync2
`default_nettype wire

// [verilog/mii_link.sv]
// MAC-facing datapath on the link clock: loopback, collision test, isolate and low power.
`include "phy_ctrl_consts.svh"
`default_nettype none
module mii_link #(
  parameter int LB_DELAY = `LOOPBACK_DELAY_CYCLES
) (
  // Link clock.
  input  wire logic       mii_clk,
  // Control levels from the core clock domain.
  input  wire logic       link_reset_req,
  input  wire logic       loopback,
  input  wire logic       coltest,
  input  wire logic       low_power,
  input  wire logic       isolate,
  // MAC transmit side.
  input  wire logic       tx_en,
  input  wire logic [3:0] txd,
  // Line receive datapath.
  input  wire logic [3:0] pma_rxd,
  input  wire logic       pma_rx_dv,
  input  wire logic       pma_crs,
  input  wire logic       pma_col,
  // MAC receive side with a shared active-low output enable.
  output var  logic [3:0] rxd,
  output var  logic       rx_dv,
  output var  logic       crs,
  output var  logic       col,
  output var  logic       mac_out_en_n,
  // Twisted-pair side.
  output var  logic [3:0] tp_txd,
  output var  logic       tp_tx_en,
  output var  logic       tp_transmit_tristate,
  output var  logic       tp_rx_enable
);

  typedef struct packed {
    logic [LB_DELAY-1:0][4:0] pipe;
    logic [3:0]               rxd;
    logic                     rx_dv;
    logic                     crs;
    logic                     col;
    logic                     out_en_n;
    logic [3:0]               tp_txd;
    logic                     tp_tx_en;
    logic                     tp_tristate;
    logic                     tp_rx_enable;
  } link_state_t;

  link_state_t cur;
  link_state_t next_cur;
  logic [4:0]  ctl_s;
  logic        txen_g;
  logic        lrst;
  logic        lb;
  logic        ctst;
  logic        lp;
  logic        iso;

  sync2 #(.WIDTH(5)) u_ctl_sync (
    .clk      (mii_clk),
    .async_in ({link_reset_req, loopback, coltest, low_power, isolate}),
    .sync_out (ctl_s)
  );

  assign lrst = ctl_s[4];
  assign lb   = ctl_s[3];
  assign ctst = ctl_s[2];
  assign lp   = ctl_s[1];
  assign iso  = ctl_s[0];

  // Inputs from the MAC are ignored while isolated or powered down.
  assign txen_g = tx_en & ~iso & ~lp;

  always_comb begin
    next_cur         = cur;
    // Loopback delay line; its length must stay far below the latency bound.
    next_cur.pipe[0] = {txen_g, txd & {4{txen_g}}};
    for (int i = 1; i < LB_DELAY; i++) begin
      next_cur.pipe[i] = cur.pipe[i-1];
    end
    if (lb) begin
      // Transmit data comes back to the receive side; the line is disabled.
      next_cur.rxd          = cur.pipe[LB_DELAY-1][3:0];
      next_cur.rx_dv        = cur.pipe[LB_DELAY-1][4];
      next_cur.crs          = txen_g;
      next_cur.tp_txd       = 4'h0;
      next_cur.tp_tx_en     = 1'b0;
      next_cur.tp_rx_enable = 1'b0;
      next_cur.col          = ctst & txen_g;
    end else begin
      next_cur.rxd          = pma_rxd;
      next_cur.rx_dv        = pma_rx_dv;
      next_cur.crs          = pma_crs;
      next_cur.tp_txd       = txd & {4{txen_g}};
      next_cur.tp_tx_en     = txen_g;
      next_cur.tp_rx_enable = 1'b1;
      // One registered stage keeps COL within one nibble of TXEN both ways.
      next_cur.col          = ctst ? txen_g : pma_col;
    end
    next_cur.tp_tristate = lp;
    next_cur.out_en_n    = iso;
    if (lp | iso) begin
      // Powered down or isolated: MAC outputs low, and released when isolated.
      next_cur.rxd          = 4'h0;
      next_cur.rx_dv        = 1'b0;
      next_cur.crs          = 1'b0;
      next_cur.col          = 1'b0;
      next_cur.tp_tx_en     = 1'b0;
      next_cur.tp_txd       = 4'h0;
      next_cur.tp_rx_enable = 1'b0;
    end
    if (lrst) begin
      next_cur          = '0;
      next_cur.out_en_n = 1'b1;
    end
  end

  always_ff @(posedge mii_clk) begin
    cur <= next_cur;
  end

  assign rxd                  = cur.rxd;
  assign rx_dv                = cur.rx_dv;
  assign crs                  = cur.crs;
  assign col                  = cur.col;
  assign mac_out_en_n         = cur.out_en_n;
  assign tp_txd               = cur.tp_txd;
  assign tp_tx_en             = cur.tp_tx_en;
  assign tp_transmit_tristate = cur.tp_tristate;
  assign tp_rx_enable         = cur.tp_rx_enable;

endmodule : mii_link
`default_nettype wire

// [test/phy_ctrl_assertions.sv]
// Concurrent checks on the ports of the basic control register block.
`default_nettype none
module phy_ctrl_assertions (
  // Clocks and reset.
  input wire logic core_clk,
  input wire logic reset,
  input wire logic mii_clk,
  // Observed pins.
  input wire logic select_pin_a,
  input wire logic rate_select_pin,
  input wire logic autoneg_select_pin,
  input wire logic mdio_out,
  input wire logic mdio_oe_n,
  input wire logic an_restart,
  input wire logic soft_reset_active,
  input wire logic mgmt_read_strobe,
  input wire logic speed_100,
  input wire logic an_enable,
  input wire logic rate_status_100,
  input wire logic rx_dv,
  input wire logic crs,
  input wire logic col,
  input wire logic mac_out_en_n
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // A read answer holds the pin for many core cycles once it starts.
  sequence drive_s; !mdio_oe_n[*8]; endsequence
  // The soft reset spans its fixed count, then ends.
  sequence srst_s; soft_reset_active[*8] ##[1:20] !soft_reset_active; endsequence
  a_ta_zero: assert property ($fell(mdio_oe_n) |-> !mdio_out) else $error("ta bit high");
  a_drive_hold: assert property ($fell(mdio_oe_n) |-> drive_s) else $error("short drive");
  a_read_answer: assert property (mgmt_read_strobe |-> ##[1:40] !mdio_oe_n)
    else $error("read not answered");
  a_srst_span: assert property ($rose(soft_reset_active) |-> srst_s) else $error("srst span");
  a_restart_pulse: assert property (an_restart |=> !an_restart) else $error("restart long");
  a_rate_status: assert property (rate_status_100 == speed_100) else $error("rate status");
  a_hw_rate_pin: assert property ((!select_pin_a && !autoneg_select_pin
    && $stable(rate_select_pin))[*6] |-> speed_100 == rate_select_pin) else $error("hw rate");
  a_hw_aneg_pin: assert property ((!select_pin_a && $stable(autoneg_select_pin))[*6]
    |-> an_enable == autoneg_select_pin) else $error("hw aneg");
  a_isolate_quiet: assert property (@(posedge mii_clk) disable iff (reset)
    mac_out_en_n |-> !rx_dv && !crs && !col) else $error("isolated outputs active");
endmodule : phy_ctrl_assertions
bind phy_basic_control_register phy_ctrl_assertions chk_i (.core_clk, .reset, .mii_clk,
  .select_pin_a, .rate_select_pin, .autoneg_select_pin, .mdio_out, .mdio_oe_n, .an_restart,
  .soft_reset_active, .mgmt_read_strobe, .speed_100, .an_enable, .rate_status_100, .rx_dv,
  .crs, .col, .mac_out_en_n);
`default_nettype wire

// [test/sta_model.sv]
// Station management controller model that runs serial management frames.
`default_nettype none
module sta_model (
  // Core clock paces the management clock.
  input  wire logic clk,
  // Data pin as driven by the PHY.
  input  wire logic mdio_out,
  input  wire logic mdio_oe_n,
  // Management clock and resolved data pin level.
  output var  logic mdc,
  output var  logic mdio_line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drv = 1'b0;
  logic dat = 1'b1;
  initial mdc = 1'b0;
  // The pin has a pull-up, so a released line reads one rather than a stale level.
  assign mdio_line = !mdio_oe_n ? mdio_out : (drv ? dat : 1'b1);
  // One slow management period; the line is taken at the very rise, before the PHY moves.
  task automatic bit_cycle(input logic d, input logic en, output logic q);
    drv <= en;
    dat <= d;
    mdc <= 1'b0;
    repeat (10) @(posedge clk);
    q = mdio_line;
    mdc <= 1'b1;
    repeat (10) @(posedge clk);
  endtask : bit_cycle
  // A whole frame with a fresh preamble; a read releases the pin for turnaround.
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [45:0] hdr;
    logic        q;
    logic        w;
    w = (op == 2'h1);
    hdr = {32'hffffffff, 2'b01, op, pa, ra};
    for (int i = 45; i >= 0; i--) bit_cycle(hdr[i], 1'b1, q);
    bit_cycle(1'b1, w, q);
    bit_cycle(1'b0, w, q);
    for (int i = 15; i >= 0; i--) begin
      bit_cycle(wd[i], w, q);
      rd[i] = q;
    end
    drv <= 1'b0;
    // One idle edge keeps the release apart from the next frame's first drive.
    @(posedge clk);
  endtask : frame
endmodule : sta_model
`default_nettype wire

// [test/testbench.sv]
// Self-checking bench for the basic control register block.
`include "phy_ctrl_consts.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, mii_clk = 0, reset = 1, mdc, mdio_in, mdio_out, mdio_oe_n;
  logic select_pin_a = 1, rate_select_pin = 0, autoneg_select_pin = 0, duplex_select_pin = 1;
  logic [4:0] phy_addr_strap = 0, mgmt_read_reg;
  logic negotiated_speed_100 = 0, autoneg_begun = 0, tx_en = 0, an_restart, soft_reset_active;
  logic negotiated_full_duplex = 1;
  logic [15:0] q_other;
  logic [3:0] txd = 0, rxd, tp_txd;
  logic latch_reinit, mgmt_read_strobe, speed_100, full_duplex, an_enable, rate_status_100;
  logic rx_dv, crs, col, mac_out_en_n, tp_tx_en, tp_transmit_tristate, tp_rx_enable;
  int num_errors = 0, n_checks = 0, restarts = 0, reinits = 0, r0;
  always #2 core_clk = ~core_clk;
  initial #1.3 forever #7.5 mii_clk = ~mii_clk;
  phy_basic_control_register dut (.core_clk, .reset, .mdc, .mdio_in, .mdio_out, .mdio_oe_n,
    .select_pin_a, .rate_select_pin, .autoneg_select_pin, .duplex_select_pin, .phy_addr_strap,
    .negotiated_speed_100, .negotiated_full_duplex, .autoneg_begun, .an_restart,
    .soft_reset_active, .latch_reinit, .mgmt_read_strobe, .mgmt_read_reg, .speed_100,
    .full_duplex, .an_enable, .rate_status_100, .mii_clk, .tx_en, .txd, .pma_rxd(4'h0),
    .pma_rx_dv(1'b0), .pma_crs(1'b0), .pma_col(1'b0), .rxd, .rx_dv, .crs, .col, .mac_out_en_n,
    .tp_txd, .tp_tx_en, .tp_transmit_tristate, .tp_rx_enable);
  sta_model sta (.clk(core_clk), .mdio_out, .mdio_oe_n, .mdc, .mdio_line(mdio_in));
  // Pulses last one cycle, so they are counted as they pass.
  always @(posedge core_clk) begin
    restarts += (an_restart === 1'b1);
    reinits += (latch_reinit === 1'b1);
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [15:0] d);
    logic [15:0] q;
    sta.frame(`MDIO_OP_WRITE, phy_addr_strap, `CTRL_REG_ADDR, d, q);
    repeat (8) @(posedge core_clk);
  endtask : wr
  task automatic rd(input logic [4:0] ra, input logic [15:0] e);
    logic [15:0] q;
    sta.frame(`MDIO_OP_READ, phy_addr_strap, ra, 16'h0000, q);
    chk(q, e);
  endtask : rd
  task automatic hard_reset(input logic [4:0] a);
    phy_addr_strap <= a;
    reset <= 1'b1;
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    repeat (30) @(posedge core_clk);
  endtask : hard_reset
  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  initial begin
    #200us;
    num_errors++;
    conclude();
  end
  // Reserved bits are always written as zero below.
  initial begin
    hard_reset(5'h00);
    rd(5'h00, 16'h3400);
    hard_reset(5'h01);
    rd(5'h00, 16'h3000);
    rd(5'h01, 16'h0000);
    chk(mgmt_read_reg, 5'h01);
    sta.frame(`MDIO_OP_READ, 5'h02, `CTRL_REG_ADDR, 16'h0000, q_other);
    chk(q_other, 16'hffff);
    chk({an_enable, speed_100, full_duplex}, 3'b101);
    wr(16'h1200);
    rd(5'h00, 16'h1200);
    autoneg_begun <= 1'b1;
    rd(5'h00, 16'h1000);
    autoneg_begun <= 1'b0;
    negotiated_speed_100 <= 1'b1;
    negotiated_full_duplex <= 1'b0;
    wr(16'h0100);
    chk({speed_100, full_duplex, an_enable}, 3'b010);
    wr(16'h0300);
    rd(5'h00, 16'h0100);
    chk(restarts, 1);
    wr(16'h6080);
    @(posedge mii_clk) tx_en <= 1'b1;
    txd <= 4'ha;
    for (int i = 0; i < 128 && rx_dv !== 1'b1; i++) @(posedge mii_clk);
    chk({rx_dv, rxd, tp_tx_en, col, crs, tp_rx_enable, tp_txd}, 13'h1a60);
    tx_en <= 1'b0;
    repeat (2) @(posedge mii_clk);
    chk(col, 0);
    wr(16'h0400);
    chk(mac_out_en_n, 1);
    rd(5'h00, 16'h0400);
    r0 = reinits;
    wr(16'h0800);
    chk(tp_transmit_tristate, 1);
    chk(16'(reinits - r0), 1);
    rd(5'h00, 16'h0800);
    wr(16'h8000);
    rd(5'h00, 16'h3000);
    select_pin_a <= 1'b0;
    repeat (10) @(posedge core_clk);
    chk({speed_100, an_enable, full_duplex, rate_status_100}, 4'h2);
    conclude();
  end
endmodule : testbench
`default_nettype wire
